// file: hdl/hdlc_cfg_pkg.sv
// package of offsets, field positions, reset values and timing for the hdlc config bank
package hdlc_cfg_pkg;
  // register indices; the bus byte address of each register is four times its index
  localparam logic [7:0] ADDR_RECOG_ACCESS_CTRL_OFS = 8'h1C;
  localparam logic [7:0] ADDR_RECOG_DATA_OFS        = 8'h1E;
  localparam logic [7:0] FILL_CHAR_OFS              = 8'h20;
  localparam logic [7:0] GCI_CHAN_CFG_0_1_OFS       = 8'h22;
  localparam logic [7:0] GCI_CHAN_CFG_2_3_OFS       = 8'h24;
  localparam logic [7:0] GCI_CHAN_CFG_4_5_OFS       = 8'h26;
  localparam logic [7:0] GCI_CHAN_CFG_6_7_OFS       = 8'h28;
  // per-channel receive config window (own)
  localparam logic [7:0] RX_CHAN_CONTROL_OFS        = 8'h40;
  localparam logic [7:0] RX_CHAN_INDEX_OFS          = 8'h44;
  // reset values
  localparam logic [15:0] ACCESS_CTRL_RST = 16'h0000;
  localparam logic [15:0] RECOG_DATA_RST  = 16'h0001;
  localparam logic [15:0] FILL_CHAR_RST   = 16'h0000;
  localparam logic [15:0] GCI_CFG_RST     = 16'h0000;
  // access control fields
  localparam int CH_LSB    = 11;
  localparam int CH_W      = 5;
  localparam int DIR_BIT   = 10;
  localparam int MASK_BIT  = 9;
  localparam logic [15:0] ACCESS_CTRL_WMASK = 16'hFE00;
  localparam logic [15:0] FILL_CHAR_WMASK   = 16'h00FF;
  // gci cfg nibble fields
  localparam int MON_EN_BIT  = 0;
  localparam int VSTAR_BIT   = 1;
  localparam int CI_EN_BIT   = 2;
  localparam int SIX_BIT_BIT = 3;
  localparam int GCI_CHANS   = 8;
  localparam int GCI_MUXES   = 2;
  // rx channel control fields
  localparam int PROTO_LSB   = 0;
  localparam int FIRST_EN_BIT  = 2;
  localparam int SECOND_EN_BIT = 3;
  localparam logic [1:0] PROTO_HDLC  = 2'h0;
  localparam logic [1:0] PROTO_TRANS1 = 2'h1;
  localparam logic [1:0] PROTO_TRANS2 = 2'h2;
  localparam int RX_CHANS = 32;
  // deselection interval
  localparam int DESEL_MS          = 125;
  localparam int FRAME_SYNC_HZ     = 8000;
  localparam int DESEL_FRAMES      = DESEL_MS * FRAME_SYNC_HZ / 1000;
  localparam logic [9:0] DESEL_FRAMES_V = 10'(DESEL_FRAMES);
  // access sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage

// file: hdl/recog_mem.sv
// little memory of per-channel recognition entries with registered read
`timescale 1ns/1ps
`default_nettype none
module recog_mem
  import hdlc_cfg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [4:0]  raddr,
  output logic      [15:0] rdata
);
  logic [15:0] mem [RX_CHANS];  // storage array
  // write port and registered read port
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // recog_mem
`default_nettype wire

// file: hdl/desel_timer.sv
// counts frame syncs a channel enable stays low; flags a completed reset interval
`timescale 1ns/1ps
`default_nettype none
module desel_timer
  import hdlc_cfg_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic frame_sync,
  output logic      reset_done
);
  logic [9:0] cnt_q;  // frames seen with enable low
  wire        hit = (cnt_q == DESEL_FRAMES_V);
  // restart on enable, count syncs while low, saturate at interval
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 10'h000;
    end else if (enable) begin
      cnt_q <= 10'h000;
    end else if (frame_sync && !hit) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  assign reset_done = hit;
endmodule // desel_timer
`default_nettype wire

// file: hdl/hdlc_addr_gci_channel_config.sv
// register bank: address recognition access, fill char, gci channel config, ahb-lite slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module hdlc_addr_gci_channel_config
  import hdlc_cfg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // receive side: address match for the channel being received
  input  wire logic        rx_byte_valid,
  input  wire logic [4:0]  rx_chan,
  input  wire logic        rx_byte_second,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_frame_reject,
  output logic             rx_msg_end,
  // gci side
  input  wire logic        frame_sync,
  output logic      [15:0] monitor_active,
  output logic      [15:0] monitor_vstar,
  output logic      [15:0] cmd_ind_active,
  output logic      [15:0] cmd_ind_six_bit,
  output logic      [15:0] monitor_reset
);
  // bus capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        rd_pend_q;
  logic [7:0]  rd_addr_q;
  // registers
  logic [15:0] access_ctrl_q;
  logic [15:0] recog_data_q;
  logic [15:0] fill_char_q;
  logic [15:0] gci_cfg_q [4];
  logic [3:0]  rx_ctrl_q [RX_CHANS];
  logic [4:0]  rx_index_q;
  acc_state_t  acc_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        reject_q;
  logic        msg_end_q;
  logic [15:0] mon_act_q;
  logic [15:0] mon_vs_q;
  logic [15:0] ci_act_q;
  logic [15:0] ci_six_q;
  logic [15:0] mon_rst_q;

  // address phase accepted
  wire take    = hsel && hready && htrans[1];
  wire take_wr = take && hwrite;
  wire take_rd = take && !hwrite;

  // write decode in data phase
  wire wr_acc   = wr_pend_q && (wr_addr_q == ADDR_RECOG_ACCESS_CTRL_OFS);
  wire wr_data  = wr_pend_q && (wr_addr_q == ADDR_RECOG_DATA_OFS);
  wire wr_fill  = wr_pend_q && (wr_addr_q == FILL_CHAR_OFS);
  wire wr_rxc   = wr_pend_q && (wr_addr_q == RX_CHAN_CONTROL_OFS);
  wire wr_rxi   = wr_pend_q && (wr_addr_q == RX_CHAN_INDEX_OFS);
  wire [15:0] wv = hwdata[15:0];

  // fields of a newly written access word
  wire [4:0] new_ch   = wv[CH_LSB +: CH_W];
  wire       new_rd   = wv[DIR_BIT];
  wire       new_mask = wv[MASK_BIT];
  wire       cur_mask = access_ctrl_q[MASK_BIT];

  // gci cfg decode: returns index 0..3 or 4 when not a gci address
  function automatic logic [2:0] gci_idx(input logic [7:0] a);
    case (a)
      GCI_CHAN_CFG_0_1_OFS: gci_idx = 3'h0;
      GCI_CHAN_CFG_2_3_OFS: gci_idx = 3'h1;
      GCI_CHAN_CFG_4_5_OFS: gci_idx = 3'h2;
      GCI_CHAN_CFG_6_7_OFS: gci_idx = 3'h3;
      default:              gci_idx = 3'h4;
    endcase
  endfunction
  wire [2:0] wr_gci = gci_idx(wr_addr_q);

  // memory ports: value and mask memories, shared channel field
  wire        mem_wr    = wr_acc && !new_rd;
  wire        val_we    = mem_wr && !new_mask;
  wire        msk_we    = mem_wr && new_mask;
  wire [4:0]  mem_raddr = (acc_q == ACC_IDLE) ? rx_chan : access_ctrl_q[CH_LSB +: CH_W];
  wire [15:0] val_rd;
  wire [15:0] msk_rd;

  recog_mem u_val_mem (
    .hclk  (hclk),
    .we    (val_we),
    .waddr (new_ch),
    .wdata (recog_data_q),
    .raddr (mem_raddr),
    .rdata (val_rd)
  );
  recog_mem u_msk_mem (
    .hclk  (hclk),
    .we    (msk_we),
    .waddr (new_ch),
    .wdata (recog_data_q),
    .raddr (mem_raddr),
    .rdata (msk_rd)
  );

  // read sequencer: launched by access write with direction set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= ACC_IDLE;
    end else begin
      case (acc_q)
        ACC_IDLE: acc_q <= (wr_acc && new_rd) ? ACC_READ : ACC_IDLE;
        ACC_READ: acc_q <= ACC_DONE;
        ACC_DONE: acc_q <= ACC_IDLE;
        default:  acc_q <= ACC_IDLE;
      endcase
    end
  end

  // bus capture of address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take_wr;
      rd_pend_q <= take_rd;
      // one aligned word per register: the index sits above the byte lanes
      if (take) begin
        wr_addr_q <= haddr[9:2];
        rd_addr_q <= haddr[9:2];
      end
    end
  end

  // stall the bus while a memory read is running; a register read gets one
  // wait state so the registered read data stand when ready is seen high
  wire busy = (acc_q != ACC_IDLE) || (wr_acc && new_rd);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= (!busy || (acc_q == ACC_DONE)) && !take_rd;
    end
  end

  // access, data, fill and index registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      access_ctrl_q <= ACCESS_CTRL_RST;
      recog_data_q  <= RECOG_DATA_RST;
      fill_char_q   <= FILL_CHAR_RST;
      rx_index_q    <= 5'h00;
    end else begin
      if (wr_acc) begin
        access_ctrl_q <= wv & ACCESS_CTRL_WMASK;
      end
      if (acc_q == ACC_DONE) begin
        recog_data_q <= cur_mask ? msk_rd : val_rd;
      end else if (wr_data) begin
        recog_data_q <= wv;
      end
      if (wr_fill) begin
        fill_char_q <= wv & FILL_CHAR_WMASK;
      end
      if (wr_rxi) begin
        rx_index_q <= wv[4:0];
      end
    end
  end

  // per-channel receive control and gci config
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RX_CHANS; i++) rx_ctrl_q[i] <= 4'h0;
      for (int g = 0; g < 4; g++) gci_cfg_q[g] <= GCI_CFG_RST;
    end else begin
      if (wr_rxc) begin
        rx_ctrl_q[rx_index_q] <= wv[3:0];
      end
      if (wr_pend_q && !wr_gci[2]) begin
        gci_cfg_q[wr_gci[1:0]] <= wv;
      end
    end
  end

  // read mux
  logic [15:0] rd_val;
  wire  [2:0]  rd_gci = gci_idx(rd_addr_q);
  always_comb begin
    rd_val = 16'h0000;
    case (rd_addr_q)
      ADDR_RECOG_ACCESS_CTRL_OFS: rd_val = access_ctrl_q;
      ADDR_RECOG_DATA_OFS:        rd_val = recog_data_q;
      FILL_CHAR_OFS:              rd_val = fill_char_q;
      RX_CHAN_CONTROL_OFS:        rd_val = {12'h000, rx_ctrl_q[rx_index_q]};
      RX_CHAN_INDEX_OFS:          rd_val = {11'h000, rx_index_q};
      default:                    rd_val = rd_gci[2] ? 16'h0000 : gci_cfg_q[rd_gci[1:0]];
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take_rd) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= {16'h0000, rd_val};
    end
  end

  // receive address recognition: memories read at rx_chan, byte one cycle later
  logic        rx_v_q;
  logic        rx_sec_q;
  logic [7:0]  rx_b_q;
  logic [4:0]  rx_ch_q;
  wire  [3:0]  ch_ctrl  = rx_ctrl_q[rx_ch_q];
  wire  [7:0]  exp_b    = rx_sec_q ? val_rd[15:8] : val_rd[7:0];
  wire  [7:0]  msk_b    = rx_sec_q ? msk_rd[15:8] : msk_rd[7:0];
  wire         miss     = |((rx_b_q ^ exp_b) & ~msk_b);
  wire         chk_en   = rx_sec_q ? ch_ctrl[SECOND_EN_BIT]
                                   : ch_ctrl[FIRST_EN_BIT];
  wire  [1:0]  proto    = ch_ctrl[PROTO_LSB +: 2];
  wire         recog_ok = rx_v_q && (acc_q == ACC_IDLE) && (proto == PROTO_HDLC);
  wire         fill_hit = rx_v_q && (proto == PROTO_TRANS1)
                          && (rx_b_q == fill_char_q[7:0]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_v_q    <= 1'b0;
      rx_sec_q  <= 1'b0;
      rx_b_q    <= 8'h00;
      rx_ch_q   <= 5'h00;
      reject_q  <= 1'b0;
      msg_end_q <= 1'b0;
    end else begin
      rx_v_q    <= rx_byte_valid;
      rx_sec_q  <= rx_byte_second;
      rx_b_q    <= rx_byte;
      rx_ch_q   <= rx_chan;
      reject_q  <= recog_ok && chk_en && miss;
      msg_end_q <= fill_hit;
    end
  end

  // gci channel flags: channel x in config word x/2; flag n from nibble n%4 of word n/4... packed
  logic [GCI_CHANS*GCI_MUXES-1:0] mon_en;
  logic [GCI_CHANS*GCI_MUXES-1:0] vs_sel;
  logic [GCI_CHANS*GCI_MUXES-1:0] ci_en;
  logic [GCI_CHANS*GCI_MUXES-1:0] six_sel;
  logic [GCI_CHANS*GCI_MUXES-1:0] mon_done;
  logic [GCI_CHANS*GCI_MUXES-1:0] ci_done;
  always_comb begin
    for (int n = 0; n < GCI_CHANS*GCI_MUXES; n++) begin
      mon_en[n]  = gci_cfg_q[n/4][(n%4)*4 + MON_EN_BIT];
      vs_sel[n]  = gci_cfg_q[n/4][(n%4)*4 + VSTAR_BIT];
      ci_en[n]   = gci_cfg_q[n/4][(n%4)*4 + CI_EN_BIT];
      six_sel[n] = gci_cfg_q[n/4][(n%4)*4 + SIX_BIT_BIT];
    end
  end

  // deselection timers for monitor and command/indicate channels
  for (genvar k = 0; k < GCI_CHANS*GCI_MUXES; k++) begin : g_timer
    desel_timer u_mon_t (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .enable     (mon_en[k]),
      .frame_sync (frame_sync),
      .reset_done (mon_done[k])
    );
    desel_timer u_ci_t (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .enable     (ci_en[k]),
      .frame_sync (frame_sync),
      .reset_done (ci_done[k])
    );
  end

  // channel activity: c/i runs only after being initialised by a low interval
  logic [15:0] ci_init_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ci_init_q <= 16'h0000;
      mon_act_q <= 16'h0000;
      mon_vs_q  <= 16'h0000;
      ci_act_q  <= 16'h0000;
      ci_six_q  <= 16'h0000;
      mon_rst_q <= 16'h0000;
    end else begin
      ci_init_q <= (ci_init_q & ci_en) | ci_done;
      mon_act_q <= mon_en;
      mon_vs_q  <= mon_en & vs_sel;
      ci_act_q  <= ci_en & (ci_init_q | ci_done);
      ci_six_q  <= ci_en & six_sel;
      mon_rst_q <= mon_done;
    end
  end

  assign hrdata          = hrdata_q;
  assign hreadyout       = hreadyout_q;
  assign hresp           = 1'b0;
  assign rx_frame_reject = reject_q;
  assign rx_msg_end      = msg_end_q;
  assign monitor_active  = mon_act_q;
  assign monitor_vstar   = mon_vs_q;
  assign cmd_ind_active  = ci_act_q;
  assign cmd_ind_six_bit = ci_six_q;
  assign monitor_reset   = mon_rst_q;

  // assertions
  sequence rd_launch_s;
    wr_acc && new_rd && (acc_q == ACC_IDLE);
  endsequence
  rd_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_launch_s |=> !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read stall wrong");
  rd_result_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_q == ACC_DONE) |=> (recog_data_q == ($past(cur_mask) ? $past(msk_rd) : $past(val_rd))))
    else $error("read result wrong");
  data_no_launch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_data |-> !val_we && !msk_we) else $error("data write launched access");
  mask_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_wr |-> (msk_we == new_mask) && (val_we == !new_mask)) else $error("mask routing wrong");
  reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (recog_ok && chk_en && miss) |=> rx_frame_reject) else $error("mismatch not rejected");
  masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_v_q && ((rx_b_q ^ exp_b) & ~msk_b) == 8'h00) |=> !rx_frame_reject)
    else $error("masked bit rejected");
  fill_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_msg_end |-> $past(rx_v_q) && ($past(rx_b_q) == $past(fill_char_q[7:0])))
    else $error("message end without fill char");
  mon_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ((monitor_active | monitor_vstar) & ~$past(mon_en)) == 16'h0000)
    else $error("monitor active while disabled");
  ci_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_ind_active & ~$past(ci_en)) == 16'h0000) else $error("c/i active while disabled");
endmodule // hdlc_addr_gci_channel_config
`default_nettype wire

// file: testbench/hdlc_addr_gci_channel_config_test.sv
// self-checking bench for the hdlc address recognition and gci channel config bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module hdlc_addr_gci_channel_config_test;
  import hdlc_cfg_pkg::*;
  logic        hclk;            // bus clock
  logic        hresetn;         // async reset, active low
  logic        hsel;            // slave select
  logic [31:0] haddr;           // byte address
  logic [1:0]  htrans;          // transfer kind
  logic        hwrite;          // write strobe
  logic [2:0]  hsize;           // word transfers only
  logic [31:0] hwdata;          // write data
  logic [31:0] hrdata;          // read data
  logic        hreadyout;       // slave ready, also the bus ready
  logic        hresp;           // response code
  logic        rx_byte_valid;   // received address byte strobe
  logic [4:0]  rx_chan;         // receive channel
  logic        rx_byte_second;  // second address byte flag
  logic [7:0]  rx_byte;         // received byte
  logic        rx_frame_reject; // frame ignored pulse
  logic        rx_msg_end;      // message end pulse
  logic        frame_sync;      // frame sync pulse
  logic [15:0] monitor_active;  // monitor channels processed
  logic [15:0] monitor_vstar;   // vstar protocol per channel
  logic [15:0] cmd_ind_active;  // c/i channels handled
  logic [15:0] cmd_ind_six_bit; // six-bit primitive per channel
  logic [15:0] monitor_reset;   // monitor channel held in reset
  int          n_errors;        // mismatches seen
  int          checks_done;     // comparisons made

  hdlc_addr_gci_channel_config dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_byte_valid(rx_byte_valid), .rx_chan(rx_chan), .rx_byte_second(rx_byte_second),
    .rx_byte(rx_byte), .rx_frame_reject(rx_frame_reject), .rx_msg_end(rx_msg_end),
    .frame_sync(frame_sync), .monitor_active(monitor_active), .monitor_vstar(monitor_vstar),
    .cmd_ind_active(cmd_ind_active), .cmd_ind_six_bit(cmd_ind_six_bit),
    .monitor_reset(monitor_reset)
  );

  // free-running 125 MHz clock
  always begin
    #4 hclk = ~hclk;
  end

  // prints the verdict and stops
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one single-word transfer; read data taken at the data phase's ready edge
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                          output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h000000, a, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {16'h0000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    `CHECK_EQ(hresp, 1'b0)
  endtask

  // register write
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] dummy;
    ahb_xfer(1'b1, a, d, dummy);
  endtask

  // register read compared with the expected low half, upper half zero
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] r;
    ahb_xfer(1'b0, a, 16'h0000, r);
    `CHECK_EQ(r, {16'h0000, e})
  endtask

  // one received address byte; watches both pulses for four cycles
  task automatic rx_send(input logic [4:0] ch, input logic sec, input logic [7:0] b,
                         input logic er, input logic ee);
    logic rj;
    logic me;
    rj = 1'b0;
    me = 1'b0;
    @(posedge hclk);
    rx_chan        <= ch;
    rx_byte_second <= sec;
    rx_byte        <= b;
    rx_byte_valid  <= 1'b1;
    @(posedge hclk);
    rx_byte_valid  <= 1'b0;
    repeat (4) begin
      @(posedge hclk);
      #1;
      rj = rj | rx_frame_reject;
      me = me | rx_msg_end;
    end
    `CHECK_EQ(rj, er)
    `CHECK_EQ(me, ee)
  endtask

  // reset values, reserved bits and an unmapped place
  task automatic t_reset();
    chk_reg(8'h1C, 16'h0000);
    chk_reg(8'h1E, 16'h0001);
    chk_reg(8'h20, 16'h0000);
    for (int i = 0; i < 4; i++) chk_reg(8'h22 + 8'(2 * i), 16'h0000);
    wr_reg(8'h30, 16'hFFFF);
    chk_reg(8'h30, 16'h0000);
    wr_reg(8'h20, 16'hFFFF);
    chk_reg(8'h20, 16'h00FF);
  endtask

  // write and read back value and mask entries of channel 5, with a channel 6 write between
  task automatic t_mem();
    wr_reg(8'h1E, 16'h3CA5);
    wr_reg(8'h1C, 16'h2800);
    wr_reg(8'h1E, 16'h0F00);
    wr_reg(8'h1C, 16'h2A00);
    wr_reg(8'h1E, 16'h0000);
    wr_reg(8'h1C, 16'h3000);
    wr_reg(8'h1C, 16'h2C00);
    chk_reg(8'h1E, 16'h3CA5);
    wr_reg(8'h1C, 16'h2E00);
    chk_reg(8'h1E, 16'h0F00);
    chk_reg(8'h1C, 16'h2E00);
  endtask

  // masked compare of both address bytes, then fill character framing
  task automatic t_match();
    wr_reg(8'h44, 16'h0005);
    wr_reg(8'h40, 16'h000C);
    rx_send(5'd5, 1'b0, 8'hA5, 1'b0, 1'b0);
    rx_send(5'd5, 1'b0, 8'hA4, 1'b1, 1'b0);
    rx_send(5'd5, 1'b1, 8'h33, 1'b0, 1'b0);
    rx_send(5'd5, 1'b1, 8'h2C, 1'b1, 1'b0);
    wr_reg(8'h40, 16'h0008);
    rx_send(5'd5, 1'b0, 8'h00, 1'b0, 1'b0);
    wr_reg(8'h20, 16'h007E);
    wr_reg(8'h40, 16'h0001);
    rx_send(5'd5, 1'b0, 8'h7E, 1'b0, 1'b1);
    rx_send(5'd5, 1'b0, 8'h7D, 1'b0, 1'b0);
    wr_reg(8'h40, 16'h0002);
    rx_send(5'd5, 1'b0, 8'h7E, 1'b0, 1'b0);
  endtask

  // frame sync pulses, one every two cycles
  task automatic pulse_fs(input int n);
    repeat (n) begin
      @(posedge hclk);
      frame_sync <= 1'b1;
      @(posedge hclk);
      frame_sync <= 1'b0;
    end
    repeat (3) @(posedge hclk);
    #1;
  endtask

  // deselection interval, then per-channel gci outputs
  task automatic t_gci();
    logic [15:0] g [4];
    logic [3:0]  nib;
    logic [15:0] em, ev, ec, es;
    g[0] = 16'h3F1D;
    g[1] = 16'hC407;
    g[2] = 16'h0F3C;
    g[3] = 16'hD1C7;
    pulse_fs(999);
    `CHECK_EQ(monitor_reset, 16'h0000)
    pulse_fs(1);
    `CHECK_EQ(monitor_reset, 16'hFFFF)
    for (int i = 0; i < 4; i++) wr_reg(8'h22 + 8'(2 * i), g[i]);
    for (int n = 0; n < 16; n++) begin
      nib   = g[n / 4][(n % 4) * 4 +: 4];
      em[n] = nib[0];
      ev[n] = nib[1] & nib[0];
      ec[n] = nib[2];
      es[n] = nib[3] & nib[2];
    end
    pulse_fs(1);
    `CHECK_EQ(monitor_active, em)
    `CHECK_EQ(monitor_vstar, ev)
    `CHECK_EQ(cmd_ind_active, ec)
    `CHECK_EQ(cmd_ind_six_bit, es)
    `CHECK_EQ(monitor_reset, ~em)
    for (int i = 0; i < 4; i++) chk_reg(8'h22 + 8'(2 * i), g[i]);
  endtask

  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rx_byte_valid = 1'b0;
    rx_chan = 5'h00;
    rx_byte_second = 1'b0;
    rx_byte = 8'h00;
    frame_sync = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge hclk);
    `CHECK_EQ(hreadyout, 1'b1)
    hresetn <= 1'b1;
    t_reset();
    t_mem();
    t_match();
    t_gci();
    complete_run();
  end

  // cuts a hang short
  initial begin
    #(8 * 20000);
    n_errors++;
    complete_run();
  end
endmodule // hdlc_addr_gci_channel_config_test
`default_nettype wire
